// [design/pwmt_pkg.sv]
// Purpose: shared constants for the timer group and watchdog
// Assumes: 32-bit Avalon-MM register bus, word addressed
// Notes:   timer n owns words n*8 .. n*8+7
package pwmt_pkg;

  // ==========================================================
  // sizes
  localparam int NTMR    = 5;
  localparam int CTRL_W  = 13;
  localparam int NEVT    = 5;
  localparam int BUS_AW  = 6;

  // ==========================================================
  // register word offsets inside one timer slot
  localparam logic [2:0] R_CTRL = 3'h0;
  localparam logic [2:0] R_PSC  = 3'h1;
  localparam logic [2:0] R_CMP0 = 3'h2;
  localparam logic [2:0] R_CMP1 = 3'h3;
  localparam logic [2:0] R_CNT  = 3'h4;
  localparam logic [2:0] R_IEN  = 3'h5;
  localparam logic [2:0] R_IST  = 3'h6;

  // global word addresses
  localparam logic [5:0] R_CAP0  = 6'h28;
  localparam logic [5:0] R_CAP1  = 6'h29;
  localparam logic [5:0] R_WDCTL = 6'h2a;
  localparam logic [5:0] R_WDST  = 6'h2b;

  // ==========================================================
  // control field positions
  localparam int C_EN    = 0;
  localparam int C_RSEL  = 1;
  localparam int C_SWCLR = 3;
  localparam int C_ACT0  = 4;
  localparam int C_ACT1  = 6;
  localparam int C_GPIO  = 8;
  localparam int C_CE0   = 9;
  localparam int C_CE1   = 11;

  // event / interrupt bit positions
  localparam int I_OVF  = 0;
  localparam int I_CMP0 = 1;
  localparam int I_CMP1 = 2;
  localparam int I_CAP0 = 3;
  localparam int I_CAP1 = 4;
  localparam int ST_PIN = 8;

  // watchdog control / status bits
  localparam int WD_EN   = 0;
  localparam int WD_SVC  = 1;
  localparam int WD_HALF = 0;
  localparam int WD_RUNB = 1;

  // ==========================================================
  // reset values and timing
  localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
  localparam logic [7:0]        PSC_RST  = 8'h00;
  localparam int                WD_TICKS = 1024;
  localparam int                RST_HOLD = 16;

  // ==========================================================
  // encodings
  typedef enum logic [1:0] {
    RS_ROLL = 2'b00, RS_CMP0 = 2'b01, RS_CMP1 = 2'b10, RS_SOFT = 2'b11
  } pwmt_rsel_e;

  typedef enum logic [1:0] {
    ACT_NONE = 2'b00, ACT_SET = 2'b01, ACT_CLR = 2'b10, ACT_TGL = 2'b11
  } pwmt_act_e;

  typedef enum logic [1:0] {
    EDG_OFF = 2'b00, EDG_RISE = 2'b01, EDG_FALL = 2'b10, EDG_BOTH = 2'b11
  } pwmt_edge_e;

  typedef enum logic [1:0] {
    WDS_OFF = 2'b00, WDS_RUN = 2'b01, WDS_BITE = 2'b10
  } pwmt_wds_e;

endpackage

// [design/pwmt_timer.sv]
// Purpose: one prescaled PWM/capture counter with two compares
// Assumes: all inputs synchronous to clk_in
// Notes:   event outputs are single-cycle pulses
`timescale 1ns/1ps
module pwmt_timer import pwmt_pkg::*; #(
  parameter int W        = 16,
  parameter bit CMP0_PIN = 1'b1,
  parameter bit HAS_CAP  = 1'b0
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // configuration
  input  wire logic [CTRL_W-1:0] ctrl_in,
  input  wire logic [7:0]       psc_in,
  input  wire logic [1:0]       cmp_wr_in,
  input  wire logic [W-1:0]     cmp_wdata_in,
  // pins
  input  wire logic [1:0]       cap_in,
  input  wire logic             pin_in,
  output logic                  pin_out,
  output logic                  pin_oe_n_out,
  // state
  output logic [W-1:0]          cnt_out,
  output logic [W-1:0]          cmp0_out,
  output logic [W-1:0]          cmp1_out,
  output logic [W-1:0]          cap0_out,
  output logic [W-1:0]          cap1_out,
  output logic [NEVT-1:0]       evt_out
);

  if (W < 2 || W > 32) begin : g_chk
    $error("pwmt_timer width out of range");
  end

  typedef struct packed {
    logic [7:0]   pre;
    logic [W-1:0] cnt;
    logic [W-1:0] c0;
    logic [W-1:0] c1;
    logic [W-1:0] s0;
    logic [W-1:0] s1;
    logic         p0;
    logic         p1;
    logic         pin;
    logic [1:0]   cprev;
    logic [W-1:0] k0;
    logic [W-1:0] k1;
  } pwmt_tmr_s;

  pwmt_tmr_s q, n;
  logic en, tick, m0, m1, hw_clr, sw_clr, ovf, cap0, cap1;
  pwmt_rsel_e rsel;

  function automatic logic act_f(input logic [1:0] a, input logic p);
    case (a)
      ACT_SET: act_f = 1'b1;
      ACT_CLR: act_f = 1'b0;
      ACT_TGL: act_f = ~p;
      default: act_f = p;
    endcase
  endfunction

  function automatic logic edge_f(input logic [1:0] c, input logic pv, input logic cur);
    case (c)
      EDG_RISE: edge_f = cur & ~pv;
      EDG_FALL: edge_f = ~cur & pv;
      EDG_BOTH: edge_f = cur ^ pv;
      default:  edge_f = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    n      = q;
    en     = ctrl_in[C_EN];
    rsel   = pwmt_rsel_e'(ctrl_in[C_RSEL +: 2]);
    tick   = en && (q.pre == psc_in);
    n.pre  = (!en || tick) ? 8'h00 : q.pre + 8'h01;
    m0     = tick && (q.cnt == q.c0);
    m1     = tick && (q.cnt == q.c1);
    hw_clr = (rsel == RS_CMP0 && m0) || (rsel == RS_CMP1 && m1);
    sw_clr = (rsel == RS_SOFT) && ctrl_in[C_SWCLR];
    ovf    = tick && (&q.cnt) && !hw_clr && !sw_clr;
    if (sw_clr) begin
      n.cnt = '0;
    end else if (tick) begin
      n.cnt = hw_clr ? '0 : q.cnt + W'(1);
    end
    // buffered compare loads only on its own match
    if (m0 && q.p0) begin
      n.c0 = q.s0;
      n.p0 = 1'b0;
    end
    if (m1 && q.p1) begin
      n.c1 = q.s1;
      n.p1 = 1'b0;
    end
    // idle timer takes writes directly, nothing to protect
    if (cmp_wr_in[0]) begin
      if (en) begin
        n.s0 = cmp_wdata_in;
        n.p0 = 1'b1;
      end else begin
        n.c0 = cmp_wdata_in;
        n.p0 = 1'b0;
      end
    end
    if (cmp_wr_in[1]) begin
      if (en) begin
        n.s1 = cmp_wdata_in;
        n.p1 = 1'b1;
      end else begin
        n.c1 = cmp_wdata_in;
        n.p1 = 1'b0;
      end
    end
    if (CMP0_PIN && m0) begin
      n.pin = act_f(ctrl_in[C_ACT0 +: 2], q.pin);
    end
    if (m1) begin
      n.pin = act_f(ctrl_in[C_ACT1 +: 2], n.pin);
    end
    cap0    = HAS_CAP && edge_f(ctrl_in[C_CE0 +: 2], q.cprev[0], cap_in[0]);
    cap1    = HAS_CAP && edge_f(ctrl_in[C_CE1 +: 2], q.cprev[1], cap_in[1]);
    n.cprev = cap_in;
    if (cap0) begin
      n.k0 = q.cnt;
    end
    if (cap1) begin
      n.k1 = q.cnt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // outputs
  assign pin_out      = q.pin;
  assign pin_oe_n_out = ctrl_in[C_GPIO];
  assign cnt_out      = q.cnt;
  assign cmp0_out     = q.c0;
  assign cmp1_out     = q.c1;
  assign cap0_out     = q.k0;
  assign cap1_out     = q.k1;
  assign evt_out      = {cap1, cap0, m1, m0, ovf};

endmodule

// [design/pwmt_top.sv]
// Purpose: timer group (one 24-bit, four 16-bit) plus watchdog
// Assumes: Avalon-MM slave, word address, one cycle of waitrequest
// Notes:   watchdog oscillator arrives as a slow synchronous level
//
// Contract
// - one 24-bit counter on the bus clock, slowed by 8-bit prescaler
// - two compare values per timer; equality gives a compare event
// - compare writes during run wait in a buffer until that match
// - two capture inputs, edge selectable, latch count into capture data
// - counter clears on rollover, compare equal, or software bit
// - 24-bit timer has five enabled interrupt sources
// - on 24-bit timer only second compare drives pin
// - pin level readable; pin can be released as plain input
// - four 16-bit counters each with own 8-bit prescaler
// - 16-bit timers interrupt on overflow and both compares
// - compare applies set, clear, toggle or no action to pin
// - watchdog counts ticks of separate slow oscillator
// - watchdog expiry asserts processor reset
// - watchdog off after reset; once enabled firmware cannot disable
// - watchdog flags half of timeout elapsed
`timescale 1ns/1ps
module pwmt_top import pwmt_pkg::*; #(
  parameter int WD_LIMIT = WD_TICKS,
  parameter int WD_HOLD  = RST_HOLD
) (
  // clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              sys_rst_in,
  // register bus
  input  wire logic [BUS_AW-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic [31:0]            avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // 24-bit timer pins
  input  wire logic              capture_input_zero_in,
  input  wire logic              capture_input_one_in,
  input  wire logic              timer_compare_pin_in,
  output logic                   timer_compare_pin_out,
  output logic                   timer_compare_pin_oe_n_out,
  // 16-bit timer pins
  input  wire logic [3:0]        pwm_pin_in,
  output logic [3:0]             pwm_pin_out,
  output logic [3:0]             pwm_pin_oe_n_out,
  // watchdog
  input  wire logic              wd_osc_in,
  output logic                   proc_rst_out,
  // interrupt requests, one per timer
  output logic [NTMR-1:0]        irq_out
);

  localparam int WD_W = $clog2(WD_LIMIT + 1);
  localparam int HD_W = $clog2(WD_HOLD + 1);

  if (WD_LIMIT < 2 || WD_HOLD < 1) begin : g_chk
    $error("pwmt_top watchdog parameters out of range");
  end

  typedef struct packed {
    logic [NTMR-1:0][CTRL_W-1:0] ctrl;
    logic [NTMR-1:0][7:0]        psc;
    logic [NTMR-1:0][NEVT-1:0]   ien;
    logic [NTMR-1:0][NEVT-1:0]   ist;
    pwmt_wds_e                   wds;
    logic [WD_W-1:0]             wcnt;
    logic                        whalf;
    logic [HD_W-1:0]             hold;
    logic                        osc_prev;
    logic                        ack;
    logic [31:0]                 rdata;
  } pwmt_top_s;

  pwmt_top_s q, n;

  // ==========================================================
  // timer instances
  logic [NTMR-1:0][23:0]     cnt_v, c0_v, c1_v;
  logic [23:0]               cap0_v, cap1_v;
  logic [NTMR-1:0][NEVT-1:0] evt_v;
  logic [NTMR-1:0][1:0]      cmp_wr_v;
  logic [NTMR-1:0]           pin_i, pin_o, pin_oe_n;
  logic [1:0]                cap_pins;

  assign pin_i    = {pwm_pin_in, timer_compare_pin_in};
  assign cap_pins = {capture_input_one_in, capture_input_zero_in};

  for (genvar g = 0; g < NTMR; g++) begin : g_tmr
    localparam int TW = (g == 0) ? 24 : 16;
    logic [TW-1:0] cnt_w, c0_w, c1_w, k0_w, k1_w;
    // first timer is the wide one with capture
    pwmt_timer #(
      .W        (TW),
      .CMP0_PIN (g != 0),
      .HAS_CAP  (g == 0)
    ) pwmt_timer_inst (
      .clk_in       (core_clk_in),
      .rst_in       (sys_rst_in),
      .ctrl_in      (q.ctrl[g]),
      .psc_in       (q.psc[g]),
      .cmp_wr_in    (cmp_wr_v[g]),
      .cmp_wdata_in (avs_writedata_in[TW-1:0]),
      .cap_in       ((g == 0) ? cap_pins : 2'b00),
      .pin_in       (pin_i[g]),
      .pin_out      (pin_o[g]),
      .pin_oe_n_out (pin_oe_n[g]),
      .cnt_out      (cnt_w),
      .cmp0_out     (c0_w),
      .cmp1_out     (c1_w),
      .cap0_out     (k0_w),
      .cap1_out     (k1_w),
      .evt_out      (evt_v[g])
    );
    assign cnt_v[g] = 24'(cnt_w);
    assign c0_v[g]  = 24'(c0_w);
    assign c1_v[g]  = 24'(c1_w);
    if (g == 0) begin : g_cap
      assign cap0_v = 24'(k0_w);
      assign cap1_v = 24'(k1_w);
    end
  end

  assign timer_compare_pin_out      = pin_o[0];
  assign timer_compare_pin_oe_n_out = pin_oe_n[0];
  assign pwm_pin_out                = pin_o[NTMR-1:1];
  assign pwm_pin_oe_n_out           = pin_oe_n[NTMR-1:1];

  // ==========================================================
  // bus helpers
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      old[b*8 +: 8] = be[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
    be_merge = old;
  endfunction

  function automatic logic hit_tmr(input logic [5:0] a, input int t, input logic [2:0] r);
    hit_tmr = (a[5:3] == 3'(t)) && (a[2:0] == r);
  endfunction

  logic        acc, wr_ok;
  logic [31:0] wd, rd;
  logic        osc_rise, svc, wr_wdctl;

  // one wait state: request seen, answer on the following edge
  // read data is latched in the wait cycle, so it shows state one edge old
  assign acc                 = (avs_read_in || avs_write_in) && !q.ack;
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !q.ack;
  assign wr_ok               = avs_write_in && q.ack;
  assign wd                  = avs_writedata_in;
  assign avs_readdata_out    = q.rdata;
  assign wr_wdctl            = wr_ok && avs_address_in == R_WDCTL && avs_byteenable_in[0];
  assign svc                 = wr_wdctl && wd[WD_SVC];
  assign osc_rise            = wd_osc_in && !q.osc_prev;

  always_comb begin
    for (int t = 0; t < NTMR; t++) begin
      cmp_wr_v[t][0] = wr_ok && hit_tmr(avs_address_in, t, R_CMP0);
      cmp_wr_v[t][1] = wr_ok && hit_tmr(avs_address_in, t, R_CMP1);
      irq_out[t]     = |(q.ist[t] & q.ien[t]);
    end
  end

  // ==========================================================
  // read mux; unmapped words read zero
  always_comb begin
    rd = 32'h0000_0000;
    for (int t = 0; t < NTMR; t++) begin
      if (hit_tmr(avs_address_in, t, R_CTRL)) begin
        rd = 32'(q.ctrl[t]);
      end
      if (hit_tmr(avs_address_in, t, R_PSC)) begin
        rd = 32'(q.psc[t]);
      end
      // compare reads show the active value, not a pending buffer
      if (hit_tmr(avs_address_in, t, R_CMP0)) begin
        rd = 32'(c0_v[t]);
      end
      if (hit_tmr(avs_address_in, t, R_CMP1)) begin
        rd = 32'(c1_v[t]);
      end
      if (hit_tmr(avs_address_in, t, R_CNT)) begin
        rd = 32'(cnt_v[t]);
      end
      if (hit_tmr(avs_address_in, t, R_IEN)) begin
        rd = 32'(q.ien[t]);
      end
      if (hit_tmr(avs_address_in, t, R_IST)) begin
        rd         = 32'(q.ist[t]);
        rd[ST_PIN] = pin_i[t];
      end
    end
    case (avs_address_in)
      R_CAP0:  rd = 32'(cap0_v);
      R_CAP1:  rd = 32'(cap1_v);
      R_WDCTL: rd = 32'(q.wds != WDS_OFF);
      R_WDST:  rd = {30'h0, q.wds != WDS_OFF, q.whalf};
      default: rd = rd;
    endcase
  end

  // ==========================================================
  // registers and watchdog
  always_comb begin
    n          = q;
    n.ack      = acc;
    n.osc_prev = wd_osc_in;
    if (acc) begin
      n.rdata = rd;
    end
    for (int t = 0; t < NTMR; t++) begin
      if (wr_ok && hit_tmr(avs_address_in, t, R_CTRL)) begin
        n.ctrl[t] = CTRL_W'(be_merge(32'(q.ctrl[t]), wd, avs_byteenable_in));
      end
      if (wr_ok && hit_tmr(avs_address_in, t, R_PSC)) begin
        n.psc[t] = 8'(be_merge(32'(q.psc[t]), wd, avs_byteenable_in));
      end
      if (wr_ok && hit_tmr(avs_address_in, t, R_IEN)) begin
        n.ien[t] = NEVT'(be_merge(32'(q.ien[t]), wd, avs_byteenable_in));
      end
      // write one clears; a same-cycle event wins
      if (wr_ok && hit_tmr(avs_address_in, t, R_IST) && avs_byteenable_in[0]) begin
        n.ist[t] = q.ist[t] & ~wd[NEVT-1:0];
      end
      n.ist[t] = n.ist[t] | evt_v[t];
    end
    case (q.wds)
      WDS_OFF: begin
        n.wcnt  = '0;
        n.whalf = 1'b0;
        if (wr_wdctl && wd[WD_EN]) begin
          n.wds = WDS_RUN;
        end
      end
      WDS_RUN: begin
        // writing zero to the enable is simply ignored here
        if (svc) begin
          n.wcnt  = '0;
          n.whalf = 1'b0;
        end else if (osc_rise) begin
          if (q.wcnt == WD_W'(WD_LIMIT - 1)) begin
            n.wds  = WDS_BITE;
            n.hold = '0;
          end else begin
            n.wcnt = q.wcnt + WD_W'(1);
          end
          n.whalf = (q.wcnt + WD_W'(1)) >= WD_W'(WD_LIMIT / 2);
        end
      end
      WDS_BITE: begin
        // only the processor is held; timers and this block keep running
        n.hold = q.hold + HD_W'(1);
        if (q.hold == HD_W'(WD_HOLD - 1)) begin
          n.wds   = WDS_RUN;
          n.wcnt  = '0;
          n.whalf = 1'b0;
        end
      end
      default: n.wds = WDS_OFF;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      q      <= '0;
      q.ctrl <= {NTMR{CTRL_RST}};
      q.psc  <= {NTMR{PSC_RST}};
      q.wds  <= WDS_OFF;
    end else begin
      q <= n;
    end
  end

  assign proc_rst_out = (q.wds == WDS_BITE);

endmodule

// [test/pwmt_top_properties.sv]
// Purpose: port-level checks for the timer group and watchdog
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound into every pwmt_top instance
`timescale 1ns/1ps
module pwmt_top_properties import pwmt_pkg::*; #(
  parameter int WD_HOLD = RST_HOLD
) (
  // clock and reset
  input wire logic              core_clk_in,
  input wire logic              sys_rst_in,
  // register bus
  input wire logic [BUS_AW-1:0] avs_address_in,
  input wire logic              avs_read_in,
  input wire logic              avs_write_in,
  input wire logic [31:0]       avs_readdata_out,
  input wire logic              avs_waitrequest_out,
  // pins and requests
  input wire logic [3:0]        pwm_pin_oe_n_out,
  input wire logic              proc_rst_out,
  input wire logic [NTMR-1:0]   irq_out
);
  // ==========================================================
  // helpers
  logic        req;
  logic        acc;
  logic [31:0] hold_r;
  assign req = avs_read_in | avs_write_in;
  assign acc = req & ~avs_waitrequest_out;

  // counts reset-pulse cycles so long holds need no repetition
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || !proc_rst_out) begin
      hold_r <= 32'h0;
    end else begin
      hold_r <= hold_r + 32'h1;
    end
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  // ==========================================================
  // assertions
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest_out)
    else $error("first request cycle not stalled");
  a_wait_single: assert property (req && avs_waitrequest_out |=> !req || !avs_waitrequest_out)
    else $error("more than one wait state");
  a_wait_idle: assert property (!req |-> !avs_waitrequest_out)
    else $error("waitrequest without request");
  a_rdata_stands: assert property ($changed(avs_readdata_out) |-> acc)
    else $error("read data moved outside acceptance");
  a_unmapped_zero: assert property (avs_read_in && acc &&
    (avs_address_in > 6'h2b || avs_address_in[2:0] == 3'h7) |-> avs_readdata_out == 32'h0)
    else $error("unmapped word read nonzero");
  a_irq_clear_write: assert property (|($past(irq_out) & ~irq_out) |->
    $past(avs_write_in && !avs_waitrequest_out) || $past(acc && avs_write_in, 2))
    else $error("interrupt dropped without a write");
  a_hold_max: assert property (proc_rst_out |-> hold_r < WD_HOLD)
    else $error("processor reset held too long");
  a_hold_len: assert property ($fell(proc_rst_out) |-> hold_r == WD_HOLD)
    else $error("processor reset pulse length wrong");
  a_reset_quiet: assert property ($fell(sys_rst_in) |->
    pwm_pin_oe_n_out == 4'h0 && irq_out == '0 && !proc_rst_out)
    else $error("outputs not quiet after reset");

  c_bus_read: cover property (avs_read_in && acc);
  c_irq: cover property ($rose(irq_out[1]));
  c_bite: cover property ($rose(proc_rst_out));
endmodule

bind pwmt_top pwmt_top_properties #(.WD_HOLD(WD_HOLD)) pwmt_top_properties_inst (
  .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .pwm_pin_oe_n_out(pwm_pin_oe_n_out), .proc_rst_out(proc_rst_out), .irq_out(irq_out));

// [test/pwmt_top_bench.sv]
// Purpose: self-checking bench for the timer group and watchdog
// Assumes: one wait state per bus access
// Notes:   watchdog shortened to 8 ticks and a 2-cycle reset pulse
`timescale 1ns/1ps
module pwmt_top_bench import pwmt_pkg::*;;
  logic            core_clk_in, sys_rst_in, avs_read_in, avs_write_in;
  logic            cap0_in, cap1_in, wd_osc_in, avs_waitrequest_out;
  logic            proc_rst_out, tpin_out, tpin_oe_n_out;
  logic [5:0]      avs_address_in;
  logic [31:0]     avs_writedata_in, avs_readdata_out, q, c0;
  logic [3:0]      pwm_ext, pwm_pin_in, pwm_pin_out, pwm_pin_oe_n_out;
  logic [NTMR-1:0] irq_out;
  int              mismatches, checks, n;

  // a released pin reads the level the bench puts on it
  assign pwm_pin_in = (pwm_pin_out & ~pwm_pin_oe_n_out) | (pwm_ext & pwm_pin_oe_n_out);

  pwmt_top #(.WD_LIMIT(8), .WD_HOLD(2)) pwmt_top_inst (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hf),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .capture_input_zero_in(cap0_in), .capture_input_one_in(cap1_in),
    .timer_compare_pin_in(tpin_out & ~tpin_oe_n_out), .timer_compare_pin_out(tpin_out),
    .timer_compare_pin_oe_n_out(tpin_oe_n_out), .pwm_pin_in(pwm_pin_in),
    .pwm_pin_out(pwm_pin_out), .pwm_pin_oe_n_out(pwm_pin_oe_n_out), .wd_osc_in(wd_osc_in),
    .proc_rst_out(proc_rst_out), .irq_out(irq_out));

  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  // ==========================================================
  // tasks
  task automatic results();
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= ~w;
    k = 0;
    do begin
      @(posedge core_clk_in);
      k++;
    end while (avs_waitrequest_out !== 1'b0 && k < 20);
    r = avs_readdata_out;
    if (avs_waitrequest_out !== 1'b0) begin
      mismatches++;
      results();
    end
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge core_clk_in);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e,
                        input logic [31:0] m = 32'hffffffff);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask

  task automatic wait_pin(input int i, input logic v);
    n = 0;
    while (pwm_pin_out[i] !== v && n < 200) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      results();
    end
  endtask

  task automatic ticks(input int k);
    repeat (k) begin
      wd_osc_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      wd_osc_in <= 1'b0;
      repeat (3) @(posedge core_clk_in);
    end
  endtask

  // ==========================================================
  // sequence
  initial begin
    sys_rst_in = 1'b1;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = 6'h00;
    avs_writedata_in = 32'h0;
    cap0_in = 1'b0;
    cap1_in = 1'b0;
    wd_osc_in = 1'b0;
    pwm_ext = 4'h0;
    mismatches = 0;
    checks = 0;
    repeat (6) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    for (int t = 0; t < NTMR; t++) begin
      rd_chk(6'(t * 8), 32'h0);
      rd_chk(6'(t * 8 + 1), 32'h0);
    end
    rd_chk(R_WDST, 32'h0);
    rd_chk(6'h07, 32'h0);
    rd_chk(6'h2c, 32'h0);
    wr(6'h0c, 32'hffff);
    rd_chk(6'h0c, 32'h0);
    // 16-bit timer: set at 2, clear and restart at 5, one step per 2 clocks
    wr(6'h09, 32'h1);
    wr(6'h0a, 32'h2);
    wr(6'h0b, 32'h5);
    wr(6'h0d, 32'h7);
    rd_chk(6'h0a, 32'h2);
    wr(6'h08, 32'h95);
    wait_pin(0, 1'b1);
    wait_pin(0, 1'b0);
    chk(n, 32'd6);
    wr(6'h0b, 32'h9);
    rd_chk(6'h0b, 32'h5);
    wait_pin(0, 1'b1);
    wait_pin(0, 1'b0);
    wait_pin(0, 1'b1);
    wait_pin(0, 1'b0);
    chk(n, 32'd14);
    rd_chk(6'h0b, 32'h9);
    wr(6'h08, 32'h94);
    chk(irq_out[1], 1'b1);
    wr(6'h0d, 32'h0);
    chk(irq_out[1], 1'b0);
    rd_chk(6'h0e, 32'h6, 32'hff);
    wr(6'h0e, 32'h7);
    rd_chk(6'h0e, 32'h0, 32'hff);
    wr(6'h10, 32'h100);
    pwm_ext <= 4'h2;
    rd_chk(6'h16, 32'h100);
    chk(pwm_pin_oe_n_out[1], 1'b1);
    // toggle on compare-0 restart at 3
    wr(6'h1a, 32'h3);
    wr(6'h18, 32'h33);
    wait_pin(2, 1'b1);
    wait_pin(2, 1'b0);
    chk(n, 32'd4);
    // last 16-bit timer: software clear holds zero, then roll over
    wr(6'h20, 32'hf);
    rd_chk(6'h24, 32'h0);
    wr(6'h20, 32'h7);
    rd_chk(6'h24, 32'h1);
    wr(6'h25, 32'h1);
    wr(6'h20, 32'h1);
    n = 0;
    while (irq_out[4] !== 1'b1 && n < 70000) begin
      @(posedge core_clk_in);
      n++;
    end
    chk(irq_out[4], 1'b1);
    // 24-bit timer capture: zero on rise, one on fall, 4 cycles apart
    wr(6'h02, 32'h3);
    wr(6'h05, 32'h18);
    wr(6'h00, 32'h1211);
    cap0_in <= 1'b1;
    cap1_in <= 1'b1;
    // status read is latched in its wait cycle, so let the edge register first
    @(posedge core_clk_in);
    rd_chk(6'h06, 32'h08, 32'h18);
    cap0_in <= 1'b0;
    cap1_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    rd_chk(6'h06, 32'h18, 32'h18);
    bus(1'b0, R_CAP0, 32'h0, c0);
    bus(1'b0, R_CAP1, 32'h0, q);
    chk(q - c0, 32'h4);
    chk(irq_out[0], 1'b1);
    chk(tpin_out, 1'b0);
    // watchdog
    wr(R_WDCTL, 32'h1);
    rd_chk(R_WDST, 32'h2);
    wr(R_WDCTL, 32'h0);
    rd_chk(R_WDST, 32'h2);
    ticks(4);
    rd_chk(R_WDST, 32'h3);
    wr(R_WDCTL, 32'h2);
    rd_chk(R_WDST, 32'h2);
    ticks(7);
    chk(proc_rst_out, 1'b0);
    wd_osc_in <= 1'b1;
    n = 0;
    while (proc_rst_out !== 1'b1 && n < 20) begin
      @(posedge core_clk_in);
      n++;
    end
    chk(proc_rst_out, 1'b1);
    results();
  end
endmodule
